// ==== rtl/rcs_cmd_select.sv ====
`timescale 1ns/1ps
module rcs_cmd_select #(
    parameter bit ADVANCED = 1'b1,
    parameter int N_TERM = ADVANCED ? 5 : 3
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input logic [N_TERM-1:0] input_terminal,
    input logic term_fault_reset,
    input logic fault_trip,
    input logic ramp_at_zero,
    input logic serial_run,
    input logic serial_rev,
    output logic motor_run,
    output logic motor_reverse,
    output logic motor_decel,
    output logic fault_active,
    output logic [7:0] serial_station_number,
    output logic serial_protocol_select,
    output logic [2:0] serial_speed_select
);
    localparam int CW = rcs_pkg::FCODE_W;
    localparam int TW = N_TERM * CW;

    typedef struct packed {
        rcs_pkg::rcs_state_t st;
        logic [1:0] src;
        logic kp_dir;
        logic [1:0] prev;
        logic autorun;
        logic restart;
        logic [TW-1:0] codes;
        logic [7:0] station;
        logic proto;
        logic [2:0] speed;
        logic kp_run;
        logic lock;
        logic pu;
        logic [1:0] settle;
        logic dir;
        logic [31:0] prdata;
    } rcs_main_st_t;

    localparam rcs_main_st_t RST_ST = '{
        st: rcs_pkg::RCS_IDLE,
        src: rcs_pkg::SRC_RST,
        kp_dir: rcs_pkg::DIR_RST,
        prev: rcs_pkg::PREV_RST,
        autorun: rcs_pkg::AUTORUN_RST,
        restart: rcs_pkg::RESTART_RST,
        codes: rcs_pkg::TFUNC_RST[TW-1:0],
        station: rcs_pkg::STN_RST,
        proto: rcs_pkg::PROTO_RST,
        speed: rcs_pkg::SPEED_RST,
        kp_run: 1'b0,
        lock: 1'b1,
        pu: 1'b1,
        settle: rcs_pkg::SETTLE_RST,
        dir: rcs_pkg::DIR_FWD,
        prdata: 32'h0
    };

    rcs_main_st_t r;
    rcs_main_st_t nxt;

    logic setup;
    logic access;
    logic hit;
    logic wr;
    logic key_wr;
    logic key_run;
    logic key_stop;
    logic frst;
    logic term_src;
    logic term_run;
    logic lock_eff;
    logic req_run;
    logic req_rev;
    logic blocked;
    logic run_ok;

    ////////////////////////////////////////////////////////////////////////
    // Terminal synchroniser and role decoder
    rcs_term_if #(.N(N_TERM), .CW(CW)) tif ();

    assign tif.raw = input_terminal;
    assign tif.codes = r.codes;

    rcs_term_dec #(.N(N_TERM)) u_dec (
        .pclk(pclk),
        .presetn(presetn),
        .t(tif.dec)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign hit = paddr == rcs_pkg::ADDR_CTRL || paddr == rcs_pkg::ADDR_TFUNC
        || paddr == rcs_pkg::ADDR_SERIAL || paddr == rcs_pkg::ADDR_KEY
        || paddr == rcs_pkg::ADDR_STATUS;
    assign wr = access & pwrite & hit;
    assign key_wr = wr && paddr == rcs_pkg::ADDR_KEY;
    assign key_run = key_wr & pwdata[rcs_pkg::KEY_RUN_BIT];
    assign key_stop = key_wr & pwdata[rcs_pkg::KEY_STOP_BIT];
    assign frst = term_fault_reset
        | (key_wr & pwdata[rcs_pkg::KEY_RESET_BIT]);

    ////////////////////////////////////////////////////////////////////////
    // Command source selection
    assign term_src = r.src == rcs_pkg::SRC_FWD_REV
        || r.src == rcs_pkg::SRC_RUN_DIR;
    // Both on or both off cancels in forward/reverse mode
    assign term_run = (r.src == rcs_pkg::SRC_FWD_REV)
        ? (tif.fwd_on ^ tif.rev_on)
        : (r.src == rcs_pkg::SRC_RUN_DIR) ? tif.fwd_on : 1'b0;
    // A terminal command held over power-up (autorun off) or a trip (restart off) is ignored
    assign lock_eff = r.lock & ~(r.pu & r.autorun)
        & ~(frst & r.restart);
    assign req_run = (r.src == rcs_pkg::SRC_KEYPAD) ? r.kp_run
        : (r.src == rcs_pkg::SRC_SERIAL)
        ? (ADVANCED & serial_run)
        : (term_run & ~lock_eff);
    assign req_rev = (r.src == rcs_pkg::SRC_KEYPAD) ? r.kp_dir
        : (r.src == rcs_pkg::SRC_SERIAL) ? serial_rev
        : tif.rev_on;
    assign blocked = (r.prev == rcs_pkg::PREV_FWD && !req_rev)
        || (r.prev == rcs_pkg::PREV_REV && req_rev);
    assign run_ok = req_run & ~blocked;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        nxt = r;
        if (setup) begin
            nxt.prdata = 32'h0;
            case (paddr)
                rcs_pkg::ADDR_CTRL: begin
                    nxt.prdata[rcs_pkg::CTRL_SRC_LSB +: 2] = r.src;
                    nxt.prdata[rcs_pkg::CTRL_DIR_BIT] = r.kp_dir;
                    nxt.prdata[rcs_pkg::CTRL_PREV_LSB +: 2] = r.prev;
                    nxt.prdata[rcs_pkg::CTRL_AUTORUN_BIT] = r.autorun;
                    nxt.prdata[rcs_pkg::CTRL_RESTART_BIT] = r.restart;
                end
                rcs_pkg::ADDR_TFUNC: begin
                    nxt.prdata[TW-1:0] = r.codes;
                end
                rcs_pkg::ADDR_SERIAL: begin
                    nxt.prdata[rcs_pkg::SER_STN_LSB +: 8] = r.station;
                    nxt.prdata[rcs_pkg::SER_PROTO_BIT] = r.proto;
                    nxt.prdata[rcs_pkg::SER_SPEED_LSB +: 3] = r.speed;
                end
                rcs_pkg::ADDR_STATUS: begin
                    nxt.prdata[rcs_pkg::STAT_ST_LSB +: 2] = r.st;
                    nxt.prdata[rcs_pkg::STAT_REQ_BIT] = run_ok;
                    nxt.prdata[rcs_pkg::STAT_DIR_BIT] = r.dir;
                    nxt.prdata[rcs_pkg::STAT_LOCK_BIT] = r.lock;
                    nxt.prdata[rcs_pkg::STAT_FWD_BIT] = tif.fwd_on;
                    nxt.prdata[rcs_pkg::STAT_REV_BIT] = tif.rev_on;
                    nxt.prdata[rcs_pkg::STAT_ADV_BIT] = ADVANCED;
                end
                default: begin
                    nxt.prdata = 32'h0;
                end
            endcase
        end
        if (wr) begin
            case (paddr)
                rcs_pkg::ADDR_CTRL: begin
                    if (ADVANCED || pwdata[rcs_pkg::CTRL_SRC_LSB +: 2]
                            != rcs_pkg::SRC_SERIAL) begin
                        nxt.src = pwdata[rcs_pkg::CTRL_SRC_LSB +: 2];
                    end
                    nxt.kp_dir = pwdata[rcs_pkg::CTRL_DIR_BIT];
                    if (pwdata[rcs_pkg::CTRL_PREV_LSB +: 2]
                            <= rcs_pkg::PREV_REV) begin
                        nxt.prev = pwdata[rcs_pkg::CTRL_PREV_LSB +: 2];
                    end
                    nxt.autorun = pwdata[rcs_pkg::CTRL_AUTORUN_BIT];
                    nxt.restart = pwdata[rcs_pkg::CTRL_RESTART_BIT];
                end
                rcs_pkg::ADDR_TFUNC: begin
                    for (int i = 0; i < N_TERM; i++) begin
                        if (pwdata[i*CW +: CW] <= rcs_pkg::FCODE_MAX) begin
                            nxt.codes[i*CW +: CW] = pwdata[i*CW +: CW];
                        end
                    end
                end
                rcs_pkg::ADDR_SERIAL: begin
                    if (pwdata[rcs_pkg::SER_STN_LSB +: 8] >= rcs_pkg::STN_MIN
                            && pwdata[rcs_pkg::SER_STN_LSB +: 8]
                            <= rcs_pkg::STN_MAX) begin
                        nxt.station = pwdata[rcs_pkg::SER_STN_LSB +: 8];
                    end
                    nxt.proto = pwdata[rcs_pkg::SER_PROTO_BIT];
                    if (pwdata[rcs_pkg::SER_SPEED_LSB +: 3]
                            <= rcs_pkg::SPEED_MAX) begin
                        nxt.speed = pwdata[rcs_pkg::SER_SPEED_LSB +: 3];
                    end
                end
                default: begin
                end
            endcase
        end
        // Keypad run latch; stop wins over run in one write
        if (r.src != rcs_pkg::SRC_KEYPAD || key_stop
                || r.st == rcs_pkg::RCS_FAULT) begin
            nxt.kp_run = 1'b0;
        end else if (key_run) begin
            nxt.kp_run = 1'b1;
        end
        // Decoded roles read off until the synchroniser has filled
        if (r.settle != 2'h0) begin
            nxt.settle = r.settle - 2'h1;
        end
        if (r.settle == 2'h0 && (!term_run || !lock_eff)) begin
            nxt.lock = 1'b0;
            nxt.pu = 1'b0;
        end
        if (run_ok) begin
            nxt.dir = req_rev;
        end
        case (r.st)
            rcs_pkg::RCS_IDLE: begin
                if (run_ok) begin
                    nxt.st = rcs_pkg::RCS_RUN;
                end
            end
            rcs_pkg::RCS_RUN: begin
                if (!run_ok) begin
                    nxt.st = rcs_pkg::RCS_DECEL;
                end
            end
            rcs_pkg::RCS_DECEL: begin
                if (run_ok) begin
                    nxt.st = rcs_pkg::RCS_RUN;
                end else if (ramp_at_zero) begin
                    nxt.st = rcs_pkg::RCS_IDLE;
                end
            end
            rcs_pkg::RCS_FAULT: begin
                if (frst) begin
                    nxt.st = run_ok ? rcs_pkg::RCS_RUN
                        : rcs_pkg::RCS_IDLE;
                end
            end
            default: begin
                nxt.st = rcs_pkg::RCS_IDLE;
            end
        endcase
        if (fault_trip) begin
            nxt.st = rcs_pkg::RCS_FAULT;
            if (!r.restart) begin
                nxt.lock = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= RST_ST;
        end else begin
            r <= nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata = r.prdata;
    assign pready = 1'b1;
    assign pslverr = access & ~hit;
    assign motor_run = r.st == rcs_pkg::RCS_RUN;
    assign motor_decel = r.st == rcs_pkg::RCS_DECEL;
    assign fault_active = r.st == rcs_pkg::RCS_FAULT;
    assign motor_reverse = r.dir;
    assign serial_station_number = r.station;
    assign serial_protocol_select = r.proto;
    assign serial_speed_select = r.speed;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_run_key;
        r.st == rcs_pkg::RCS_IDLE && r.src == rcs_pkg::SRC_KEYPAD
        && key_run && !key_stop && r.prev == rcs_pkg::PREV_NONE
        && !fault_trip;
    endsequence

    sequence s_stop_key;
        r.st == rcs_pkg::RCS_RUN && r.src == rcs_pkg::SRC_KEYPAD
        && key_stop && !fault_trip;
    endsequence

    a_run_key_start: assert property (s_run_key ##1 !fault_trip
        |=> motor_run)
        else $error("Run key did not start the motor");

    a_stop_key_decel: assert property (s_stop_key ##1 !fault_trip
        |=> motor_decel && !motor_run)
        else $error("Stop key did not start deceleration");

    a_keypad_dir: assert property (r.src == rcs_pkg::SRC_KEYPAD
        && r.kp_run && !blocked |=> motor_reverse == $past(r.kp_dir))
        else $error("Keypad direction not applied");

    a_both_on_stop: assert property (r.st == rcs_pkg::RCS_RUN
        && r.src == rcs_pkg::SRC_FWD_REV && tif.fwd_on == tif.rev_on
        && !fault_trip |=> motor_decel)
        else $error("Equal run terminals did not stop");

    a_run_dir_mode: assert property (r.st == rcs_pkg::RCS_IDLE
        && r.src == rcs_pkg::SRC_RUN_DIR && tif.fwd_on && !lock_eff
        && !blocked && !fault_trip
        |=> motor_run && motor_reverse == $past(tif.rev_on))
        else $error("Run and direction terminals misapplied");

    a_serial_only_adv: assert property (ADVANCED
        || r.src != rcs_pkg::SRC_SERIAL)
        else $error("Serial source on standard model");

    a_station_range: assert property (r.station >= rcs_pkg::STN_MIN
        && r.station <= rcs_pkg::STN_MAX
        && r.speed <= rcs_pkg::SPEED_MAX)
        else $error("Serial setting out of range");

    a_prevent_block: assert property (r.st == rcs_pkg::RCS_IDLE
        && blocked |=> !motor_run)
        else $error("Prevented direction was started");

    a_lock_holds: assert property (term_src && r.lock && term_run
        && !(r.pu && r.autorun) && !(frst && r.restart) |-> !req_run)
        else $error("Held terminal run was not ignored");

    a_reset_restart: assert property (r.st == rcs_pkg::RCS_FAULT && frst
        && r.restart && term_src && term_run && !blocked && !fault_trip
        |=> motor_run)
        else $error("Restart after fault reset missing");

endmodule : rcs_cmd_select

// ==== rtl/rcs_pkg.sv ====
package rcs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_TFUNC = 12'h004;
    localparam logic [11:0] ADDR_SERIAL = 12'h008;
    localparam logic [11:0] ADDR_KEY = 12'h00c;
    localparam logic [11:0] ADDR_STATUS = 12'h010;

    ////////////////////////////////////////////////////////////////////////
    // Control word layout
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_DIR_BIT = 4;
    localparam int CTRL_PREV_LSB = 8;
    localparam int CTRL_AUTORUN_BIT = 12;
    localparam int CTRL_RESTART_BIT = 16;

    localparam logic [1:0] SRC_KEYPAD = 2'h0;
    localparam logic [1:0] SRC_FWD_REV = 2'h1;
    localparam logic [1:0] SRC_RUN_DIR = 2'h2;
    localparam logic [1:0] SRC_SERIAL = 2'h3;
    localparam logic [1:0] SRC_RST = 2'h1;

    localparam logic DIR_FWD = 1'h0;
    localparam logic DIR_RST = 1'h0;

    localparam logic [1:0] PREV_NONE = 2'h0;
    localparam logic [1:0] PREV_FWD = 2'h1;
    localparam logic [1:0] PREV_REV = 2'h2;
    localparam logic [1:0] PREV_RST = 2'h0;
    localparam logic AUTORUN_RST = 1'h0;
    // Edges until the terminal synchroniser and decoder hold real levels
    localparam logic [1:0] SETTLE_RST = 2'h3;
    localparam logic RESTART_RST = 1'h0;

    ////////////////////////////////////////////////////////////////////////
    // Terminal function codes, one field per terminal
    localparam int FCODE_W = 5;
    localparam logic [4:0] FCODE_MAX = 5'h1b;
    localparam logic [4:0] FCODE_FWD = 5'h00;
    localparam logic [4:0] FCODE_REV = 5'h01;
    localparam logic [24:0] TFUNC_RST = 25'h0418820;

    ////////////////////////////////////////////////////////////////////////
    // Serial settings layout and limits
    localparam int SER_STN_LSB = 0;
    localparam int SER_PROTO_BIT = 8;
    localparam int SER_SPEED_LSB = 16;
    localparam logic [7:0] STN_MIN = 8'h01;
    localparam logic [7:0] STN_MAX = 8'hfa;
    localparam logic [7:0] STN_RST = 8'h01;
    localparam logic PROTO_RST = 1'h0;
    localparam logic [2:0] SPEED_MAX = 3'h4;
    localparam logic [2:0] SPEED_RST = 3'h3;

    ////////////////////////////////////////////////////////////////////////
    // Key strobe bits and status bits
    localparam int KEY_RUN_BIT = 0;
    localparam int KEY_STOP_BIT = 1;
    localparam int KEY_RESET_BIT = 2;
    localparam int STAT_ST_LSB = 0;
    localparam int STAT_REQ_BIT = 2;
    localparam int STAT_DIR_BIT = 3;
    localparam int STAT_LOCK_BIT = 4;
    localparam int STAT_FWD_BIT = 5;
    localparam int STAT_REV_BIT = 6;
    localparam int STAT_ADV_BIT = 7;

    typedef enum logic [1:0] {
        RCS_IDLE = 2'h0,
        RCS_RUN = 2'h1,
        RCS_DECEL = 2'h3,
        RCS_FAULT = 2'h2
    } rcs_state_t;

endpackage : rcs_pkg

// ==== rtl/rcs_term_if.sv ====
`timescale 1ns/1ps
interface rcs_term_if #(
    parameter int N = 5,
    parameter int CW = 5
);
    logic [N-1:0] raw;
    logic [N*CW-1:0] codes;
    logic fwd_on;
    logic rev_on;

    modport dec (input raw, input codes, output fwd_on, output rev_on);
    modport ctl (output raw, output codes, input fwd_on, input rev_on);
endinterface : rcs_term_if

// ==== rtl/rcs_term_dec.sv ====
`timescale 1ns/1ps
module rcs_term_dec #(
    parameter int N = 5
) (
    input logic pclk,
    input logic presetn,
    rcs_term_if.dec t
);
    localparam int CW = rcs_pkg::FCODE_W;

    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic fwd;
        logic rev;
    } rcs_dec_st_t;

    rcs_dec_st_t r;
    rcs_dec_st_t nxt;

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchroniser, then role decode on the second stage
    always_comb begin
        nxt = r;
        nxt.s1 = t.raw;
        nxt.s2 = r.s1;
        nxt.fwd = 1'b0;
        nxt.rev = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (t.codes[i*CW +: CW] == rcs_pkg::FCODE_FWD && r.s2[i]) begin
                nxt.fwd = 1'b1;
            end
            if (t.codes[i*CW +: CW] == rcs_pkg::FCODE_REV && r.s2[i]) begin
                nxt.rev = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign t.fwd_on = r.fwd;
    assign t.rev_on = r.rev;

    a_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
        (t.raw[0] && t.codes[CW-1:0] == rcs_pkg::FCODE_FWD)[*3]
        |=> t.fwd_on)
        else $error("Terminal run not seen after sync delay");

endmodule : rcs_term_dec

// ==== tb/rcs_far_side.sv ====
`timescale 1ns/1ps
// Terminal contacts and a serial host at the far side of the selector
module rcs_far_side #(
    parameter logic [7:0] HOST_STN = 8'h05
) (
    input logic pclk,
    input logic presetn,
    input logic [4:0] want_term,
    input logic want_run,
    input logic want_rev,
    input logic [7:0] dev_stn,
    output logic [4:0] input_terminal,
    output logic serial_run,
    output logic serial_rev
);
    initial input_terminal = 5'h00;

    // Contacts keep their level through a device reset
    always @(posedge pclk) begin
        input_terminal <= want_term;
    end

    // Host only commands the station it was set up for
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_run <= 1'b0;
            serial_rev <= 1'b0;
        end else begin
            serial_run <= want_run && (dev_stn == HOST_STN);
            serial_rev <= want_rev && (dev_stn == HOST_STN);
        end
    end
endmodule : rcs_far_side

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
    localparam logic [11:0] A_CT = rcs_pkg::ADDR_CTRL;
    localparam logic [11:0] A_TF = rcs_pkg::ADDR_TFUNC;
    localparam logic [11:0] A_SE = rcs_pkg::ADDR_SERIAL;
    localparam logic [11:0] A_KY = rcs_pkg::ADDR_KEY;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [4:0] input_terminal;
    logic term_fault_reset = 1'b0;
    logic fault_trip = 1'b0;
    logic ramp_at_zero = 1'b1;
    logic serial_run;
    logic serial_rev;
    logic motor_run;
    logic motor_reverse;
    logic motor_decel;
    logic fault_active;
    logic [7:0] stn;
    logic proto;
    logic [2:0] speed;
    logic [4:0] want_term = 5'h00;
    logic want_run = 1'b0;
    logic want_rev = 1'b0;
    logic [31:0] q;
    logic e;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;

    rcs_cmd_select #(.ADVANCED(1'b1), .N_TERM(5)) i_rcs_cmd_select (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .input_terminal(input_terminal),
        .term_fault_reset(term_fault_reset), .fault_trip(fault_trip),
        .ramp_at_zero(ramp_at_zero), .serial_run(serial_run),
        .serial_rev(serial_rev), .motor_run(motor_run),
        .motor_reverse(motor_reverse), .motor_decel(motor_decel),
        .fault_active(fault_active), .serial_station_number(stn),
        .serial_protocol_select(proto), .serial_speed_select(speed));

    rcs_far_side #(.HOST_STN(8'h05)) i_rcs_far_side (
        .pclk(pclk), .presetn(presetn), .want_term(want_term),
        .want_run(want_run), .want_rev(want_rev), .dev_stn(stn),
        .input_terminal(input_terminal), .serial_run(serial_run),
        .serial_rev(serial_rev));

    always #12.5 pclk = ~pclk;

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (err_total == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    task automatic chk(input string n, input logic [31:0] x,
                       input logic [31:0] g);
        total_checks++;
        if (g !== x) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input string n, input logic [11:0] a,
                      input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(n, x, q);
    endtask : rd

    // Lets the sync and decode stages settle before looking
    task automatic mot(input logic r, input logic v);
        repeat (8) @(posedge pclk);
        chk("motor_run", {31'h0, r}, {31'h0, motor_run});
        if (r) chk("motor_reverse", {31'h0, v}, {31'h0, motor_reverse});
    endtask : mot

    task automatic pulse(input logic [1:0] k);
        @(posedge pclk);
        fault_trip <= k[0];
        term_fault_reset <= k[1];
        @(posedge pclk);
        fault_trip <= 1'b0;
        term_fault_reset <= 1'b0;
    endtask : pulse

    function automatic logic [1:0] exp_motor(input logic [1:0] s,
        input logic f, input logic r, input logic [1:0] p);
        logic run;
        run = (s == rcs_pkg::SRC_FWD_REV) ? (f ^ r) : f;
        if ((p == rcs_pkg::PREV_FWD && !r) || (p == rcs_pkg::PREV_REV && r))
            run = 1'b0;
        return {run, r};
    endfunction : exp_motor

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [1:0] s;
        logic [1:0] p;
        logic [4:0] t;
        logic [1:0] m;
        void'($urandom(32'ha23b));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd("ctrl", A_CT, 32'h1);
        rd("tfunc", A_TF, {7'h0, rcs_pkg::TFUNC_RST});
        rd("serial", A_SE, 32'h00030001);
        apb(1'b0, 12'h014, 32'h0);
        chk("pslverr", 32'h1, {31'h0, e});
        apb(1'b0, rcs_pkg::ADDR_STATUS, 32'h0);
        chk("advanced", 32'h1, {31'h0, q[7]});
        want_term <= 5'h01;
        repeat (2) @(posedge pclk);
        chk("motor_run", 32'h0, {31'h0, motor_run});
        mot(1'b1, 1'b0);
        for (int i = 0; i < 24; i++) begin
            s = 2'($urandom_range(2, 1));
            p = 2'($urandom_range(2, 0));
            t = 5'($urandom);
            wr(A_CT, {22'h0, p, 6'h0, s});
            want_term <= t;
            m = exp_motor(s, t[0], t[1], p);
            mot(m[1], m[0]);
        end
        want_term <= 5'h00;
        ramp_at_zero <= 1'b0;
        wr(A_CT, 32'h10);
        wr(A_KY, 32'h1);
        mot(1'b1, 1'b1);
        wr(A_KY, 32'h2);
        repeat (3) @(posedge pclk);
        chk("motor_decel", 32'h1, {31'h0, motor_decel});
        ramp_at_zero <= 1'b1;
        mot(1'b0, 1'b0);
        chk("motor_decel", 32'h0, {31'h0, motor_decel});
        wr(A_CT, 32'h11);
        rd("ctrl", A_CT, 32'h11);
        want_term <= 5'h01;
        mot(1'b1, 1'b0);
        want_term <= 5'h00;
        wr(A_CT, 32'h2);
        wr(A_TF, 32'h00418801);
        wr(A_TF, 32'h0041881c);
        rd("tfunc", A_TF, 32'h00418801);
        want_term <= 5'h02;
        mot(1'b1, 1'b0);
        want_term <= 5'h03;
        mot(1'b1, 1'b1);
        want_term <= 5'h00;
        mot(1'b0, 1'b0);
        wr(A_TF, {7'h0, rcs_pkg::TFUNC_RST});
        wr(A_SE, 32'h000401fb);
        rd("serial", A_SE, 32'h00040101);
        wr(A_SE, 32'h00040105);
        @(posedge pclk);
        chk("serial_out", 32'h00040105,
            {13'h0, speed, 7'h0, proto, stn});
        wr(A_CT, 32'h3);
        want_run <= 1'b1;
        want_rev <= 1'b1;
        mot(1'b1, 1'b1);
        want_run <= 1'b0;
        mot(1'b0, 1'b0);
        wr(A_CT, 32'h00010001);
        want_term <= 5'h01;
        mot(1'b1, 1'b0);
        pulse(2'h1);
        repeat (2) @(posedge pclk);
        chk("fault_active", 32'h1, {31'h0, fault_active});
        pulse(2'h2);
        mot(1'b1, 1'b0);
        pulse(2'h1);
        wr(A_KY, 32'h4);
        mot(1'b1, 1'b0);
        wr(A_CT, 32'h1);
        pulse(2'h1);
        pulse(2'h2);
        mot(1'b0, 1'b0);
        want_term <= 5'h00;
        mot(1'b0, 1'b0);
        want_term <= 5'h01;
        mot(1'b1, 1'b0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        mot(1'b0, 1'b0);
        wr(A_CT, 32'h1001);
        mot(1'b1, 1'b0);
        end_of_test();
    end
endmodule : tb
